// File: src/filtered_capture_interval_timer.sv
// Top of the 8-bit capture/interval timer with a Wishbone register slave.
// Assumes a classic single-cycle Wishbone master, one 200 MHz clock, and an
// asynchronous capture pin and watch clock that are synchronised here.
// Behaviour
// - Filter shifts pin level through five latches, updates only on full agreement.
// - Filter select 0 samples the filter on every system clock.
// - Filter select 1 samples the pin on rising edges of the count clock.
// - After reset the filter output settles after five low samples.
// - Filtered capture edges lag the pin by five sampling clocks.
// - Pin function select 1 gives capture mode, 0 gives interval mode.
// - Reset clears mode register, counter and both capture registers.
// - After reset the counter runs on the system clock divided by 64.
// - Rising edge stores counter in rising register, falling in falling register.
// - Selected capture edge sets request flag; enable gates the CPU interrupt.
// - Capture mode clears counter on rising, falling, both or no edges.
// - Capture-mode overflow sets high flag if input high, else low flag.
// - Overflow flag with overflow enable sets the request flag.
// - Interval mode counts selected clock; wrap sets the low overflow flag.
// - The counter increments on each falling edge of the selected clock.
// - A clock select write from high to low level counts once.
// - Watch clock divided by 4 is synchronised, allowing one clock of error.
// - In watch mode only the watch clock source runs counter and filter.
// - Subactive runs only with watch source and subclock of watch divided by 2.
// - Spurious edges from select changes are handled like real pin edges.
// - Clock select 00 /64, 01 /32, 10 /2, 11 watch clock /4.
// - Clear select 00 none, 01 falling, 10 rising, 11 both edges.
// - Overflow flags clear by writing 0 after reading 1; writing 1 does nothing.
//
// Implementation choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
module filtered_capture_interval_timer (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [tmr_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [tmr_pkg::DATA_W-1:0] wb_dat_i,
  output logic [tmr_pkg::DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic capture_pin_i,
  input wire logic watch_clk_i,
  input wire tmr_pkg::pwr_mode_t pwr_mode_i,
  input wire logic subclk_is_watch_div2_i,
  output logic timer_irq_o
);
  import tmr_pkg::*;

  timer_mode_reg_t mode_ff;
  timer_mode_reg_t nxt_mode;
  ctl_reg_t ctl_ff;
  ctl_reg_t nxt_ctl;
  logic [CNT_W-1:0] up_counter_ff;
  logic [CNT_W-1:0] nxt_up_counter;
  logic [CNT_W-1:0] falling_capture_reg_ff;
  logic [CNT_W-1:0] rising_capture_reg_ff;
  logic ack_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic [DATA_W-1:0] rd_mux;
  logic pin_s1_ff;
  logic pin_s2_ff;
  logic cap_level_ff;
  logic armed_hi_ff;
  logic armed_lo_ff;
  logic irq_ff;
  logic count_tick;
  logic sample_tick;
  logic filt_out;
  edge_t cap_edge;

  function automatic logic clear_match(input logic [1:0] clr, input edge_t e);
    return (clr[1] & e.rise) | (clr[0] & e.fall);
  endfunction

  // Bus decode. The write lands on the edge where the master sees ack.
  wire [IDX_W-1:0] reg_idx = wb_adr_i[ADDR_W-1:2];
  wire req = wb_cyc_i & wb_stb_i;
  wire acc = req & ~ack_ff;
  wire wr_fire = req & wb_we_i & ack_ff & wb_sel_i[0];
  wire rd_acc = acc & ~wb_we_i;
  wire hit_mode = reg_idx == IDX_MODE;
  wire hit_fall = reg_idx == IDX_FALL_CAP;
  wire hit_rise = reg_idx == IDX_RISE_CAP;
  wire hit_ctl = reg_idx == IDX_CTL;
  wire wr_mode = wr_fire & hit_mode;
  wire wr_ctl = wr_fire & hit_ctl;
  wire rd_mode = rd_acc & hit_mode;
  wire [7:0] wdat = wb_dat_i[7:0];
  timer_mode_reg_t wr_mode_val;
  ctl_reg_t wr_ctl_val;
  assign wr_mode_val = wdat;
  assign wr_ctl_val = wdat[3:0];

  always_comb
  begin
    if (hit_mode)
      rd_mux = {24'h00_0000, mode_ff};
    else if (hit_fall)
      rd_mux = {24'h00_0000, falling_capture_reg_ff};
    else if (hit_rise)
      rd_mux = {24'h00_0000, rising_capture_reg_ff};
    else if (hit_ctl)
      rd_mux = {28'h000_0000, ctl_ff};
    else
      rd_mux = RD_ZERO;
  end

  // Power mode gating of both counter and filter.
  wire w4_sel = mode_ff.count_clock_select == CKS_W4;
  wire run = (pwr_mode_i == PWR_ACTIVE) ? 1'b1 :
             (pwr_mode_i == PWR_WATCH) ? w4_sel :
             (w4_sel & subclk_is_watch_div2_i);

  count_clock_gen u_clk (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .watch_clk_i(watch_clk_i),
    .cks_i(mode_ff.count_clock_select),
    .count_tick_o(count_tick),
    .sample_tick_o(sample_tick)
  );

  wire filt_sample = run & (ctl_ff.filter_select ? sample_tick : 1'b1);

  glitch_filter u_filt (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sample_i(filt_sample),
    .din_i(pin_s2_ff),
    .dout_o(filt_out)
  );

  // Changing either select switches this level directly, so a spurious edge
  // is produced and handled exactly as a pin edge would be.
  wire cap_sig = ctl_ff.capture_pin_function_select &
                 (ctl_ff.filter_select ? filt_out : pin_s2_ff);
  assign cap_edge.rise = run & cap_sig & ~cap_level_ff;
  assign cap_edge.fall = run & ~cap_sig & cap_level_ff;

  wire capture_mode = ctl_ff.capture_pin_function_select;
  wire clr_hit = capture_mode & clear_match(mode_ff.counter_clear_select, cap_edge);
  wire inc = run & count_tick;
  wire ovf = inc & (up_counter_ff == CNT_MAX) & ~clr_hit;
  wire ovf_hi_set = ovf & capture_mode & cap_sig;
  wire ovf_lo_set = ovf & ~(capture_mode & cap_sig);
  wire edge_irq = mode_ff.capture_irq_edge_select ? cap_edge.fall : cap_edge.rise;
  wire ovf_irq = mode_ff.overflow_irq_enable & (ovf_hi_set | ovf_lo_set);
  wire irq_set = edge_irq | ovf_irq;

  // Flags: hardware set wins over a software clear in the same cycle.
  wire clr_hi = wr_mode & ~wr_mode_val.overflow_at_high_flag & armed_hi_ff;
  wire clr_lo = wr_mode & ~wr_mode_val.overflow_at_low_flag & armed_lo_ff;
  wire clr_req = wr_ctl & ~wr_ctl_val.timer_irq_request_flag;

  always_comb
  begin
    nxt_mode = mode_ff;
    if (wr_mode)
    begin
      nxt_mode.overflow_irq_enable = wr_mode_val.overflow_irq_enable;
      nxt_mode.capture_irq_edge_select = wr_mode_val.capture_irq_edge_select;
      nxt_mode.counter_clear_select = wr_mode_val.counter_clear_select;
      nxt_mode.count_clock_select = wr_mode_val.count_clock_select;
    end
    nxt_mode.overflow_at_high_flag = ovf_hi_set | (mode_ff.overflow_at_high_flag & ~clr_hi);
    nxt_mode.overflow_at_low_flag = ovf_lo_set | (mode_ff.overflow_at_low_flag & ~clr_lo);
  end

  always_comb
  begin
    nxt_ctl = ctl_ff;
    if (wr_ctl)
    begin
      nxt_ctl.timer_irq_enable = wr_ctl_val.timer_irq_enable;
      nxt_ctl.filter_select = wr_ctl_val.filter_select;
      nxt_ctl.capture_pin_function_select = wr_ctl_val.capture_pin_function_select;
    end
    nxt_ctl.timer_irq_request_flag = irq_set | (ctl_ff.timer_irq_request_flag & ~clr_req);
  end

  always_comb
  begin
    if (clr_hit)
      nxt_up_counter = CNT_RST;
    else if (inc)
      nxt_up_counter = up_counter_ff + CNT_ONE;
    else
      nxt_up_counter = up_counter_ff;
  end

  // Bus slave: ack one cycle after the request, dropped the cycle after.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_ff <= 1'b0;
      rdata_ff <= RD_ZERO;
    end
    else
    begin
      ack_ff <= acc;
      if (rd_acc)
        rdata_ff <= rd_mux;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mode_ff <= MODE_RST;
      ctl_ff <= CTL_RST;
      up_counter_ff <= CNT_RST;
      falling_capture_reg_ff <= CNT_RST;
      rising_capture_reg_ff <= CNT_RST;
    end
    else
    begin
      mode_ff <= nxt_mode;
      ctl_ff <= nxt_ctl;
      up_counter_ff <= nxt_up_counter;
      if (cap_edge.rise)
        rising_capture_reg_ff <= up_counter_ff;
      if (cap_edge.fall)
        falling_capture_reg_ff <= up_counter_ff;
    end
  end

  // A flag is armed for clearing only once software has read it as set.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      armed_hi_ff <= 1'b0;
      armed_lo_ff <= 1'b0;
    end
    else
    begin
      armed_hi_ff <= nxt_mode.overflow_at_high_flag &
                     (armed_hi_ff | (rd_mode & mode_ff.overflow_at_high_flag));
      armed_lo_ff <= nxt_mode.overflow_at_low_flag &
                     (armed_lo_ff | (rd_mode & mode_ff.overflow_at_low_flag));
    end
  end

  // Pin synchroniser and capture level history; the level holds while stopped
  // so no edge is seen or lost across a halt.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_s1_ff <= 1'b0;
      pin_s2_ff <= 1'b0;
      cap_level_ff <= 1'b0;
      irq_ff <= 1'b0;
    end
    else
    begin
      pin_s1_ff <= capture_pin_i;
      pin_s2_ff <= pin_s1_ff;
      if (run)
        cap_level_ff <= cap_sig;
      irq_ff <= ctl_ff.timer_irq_request_flag & ctl_ff.timer_irq_enable;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdata_ff;
  assign timer_irq_o = irq_ff;

  property p_reset_clear;
    @(posedge clk_i) disable iff (rst_i)
      $fell(rst_i) |-> (up_counter_ff == CNT_RST) && (mode_ff == MODE_RST)
        && (rising_capture_reg_ff == CNT_RST) && (falling_capture_reg_ff == CNT_RST);
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("Registers were not cleared by reset.");

  property p_rise_capture;
    @(posedge clk_i) disable iff (rst_i)
      cap_edge.rise |=> rising_capture_reg_ff == $past(up_counter_ff);
  endproperty
  a_rise_capture: assert property (p_rise_capture)
    else $error("Rising capture register missed the counter value.");

  property p_fall_capture;
    @(posedge clk_i) disable iff (rst_i)
      cap_edge.fall |=> falling_capture_reg_ff == $past(up_counter_ff);
  endproperty
  a_fall_capture: assert property (p_fall_capture)
    else $error("Falling capture register missed the counter value.");

  property p_clear_edge;
    @(posedge clk_i) disable iff (rst_i)
      (capture_mode && ((mode_ff.counter_clear_select == CLR_BOTH && (cap_edge.rise || cap_edge.fall))
        || (mode_ff.counter_clear_select == CLR_RISE && cap_edge.rise)))
        |=> up_counter_ff == CNT_RST;
  endproperty
  a_clear_edge: assert property (p_clear_edge)
    else $error("Counter was not cleared on the selected edge.");

  property p_ovf_high;
    @(posedge clk_i) disable iff (rst_i)
      (inc && up_counter_ff == CNT_MAX && !clr_hit && capture_mode && cap_sig)
        |=> mode_ff.overflow_at_high_flag && up_counter_ff == CNT_RST;
  endproperty
  a_ovf_high: assert property (p_ovf_high)
    else $error("High-level overflow flag was not set.");

  property p_ovf_interval;
    @(posedge clk_i) disable iff (rst_i)
      (inc && up_counter_ff == CNT_MAX && !capture_mode) |=> mode_ff.overflow_at_low_flag;
  endproperty
  a_ovf_interval: assert property (p_ovf_interval)
    else $error("Interval overflow did not set the low-level flag.");

  property p_halt;
    @(posedge clk_i) disable iff (rst_i)
      (!run && $stable(up_counter_ff)) ##0 !run |=> up_counter_ff == $past(up_counter_ff);
  endproperty
  a_halt: assert property (p_halt)
    else $error("Counter moved while the timer was halted.");

  property p_irq_out;
    @(posedge clk_i) disable iff (rst_i)
      edge_irq ##1 ctl_ff.timer_irq_enable |=> timer_irq_o;
  endproperty
  a_irq_out: assert property (p_irq_out)
    else $error("Capture edge did not raise the interrupt output.");

  property p_flag_hold;
    @(posedge clk_i) disable iff (rst_i)
      (mode_ff.overflow_at_low_flag && !armed_lo_ff) |=> mode_ff.overflow_at_low_flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("Low overflow flag cleared without a prior read.");

endmodule

// File: src/tmr_pkg.sv
// Shared constants, register indices and carrier types for the capture/interval timer.
// Assumes a 32-bit classic Wishbone register bus and a 200 MHz system clock.
package tmr_pkg;

  // Printed register offsets are kept as word indices; byte address = 4 * index.
  localparam int ADDR_W = 18;
  localparam int IDX_W = 16;
  localparam logic [IDX_W-1:0] IDX_MODE = 16'hFFBC;
  localparam logic [IDX_W-1:0] IDX_FALL_CAP = 16'hFFBD;
  localparam logic [IDX_W-1:0] IDX_RISE_CAP = 16'hFFBE;
  localparam logic [IDX_W-1:0] IDX_CTL = 16'hFFC0;

  localparam int DATA_W = 32;
  localparam int CNT_W = 8;
  localparam int FILT_DEPTH = 5;
  localparam logic [CNT_W-1:0] CNT_RST = 8'h00;
  localparam logic [CNT_W-1:0] CNT_MAX = 8'hFF;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
  localparam logic [DATA_W-1:0] RD_ZERO = 32'h0000_0000;

  // Divider taps: bit n of a free counter is the clock divided by 2^(n+1).
  localparam int DIV_W = 6;
  localparam int DIV64_BIT = 5;
  localparam int DIV32_BIT = 4;
  localparam int DIV2_BIT = 0;
  localparam int WDIV_W = 2;
  localparam logic [DIV_W-1:0] DIV_ONE = 6'h01;
  localparam logic [WDIV_W-1:0] WDIV_ONE = 2'h1;

  localparam logic [1:0] CKS_D64 = 2'h0;
  localparam logic [1:0] CKS_D32 = 2'h1;
  localparam logic [1:0] CKS_D2 = 2'h2;
  localparam logic [1:0] CKS_W4 = 2'h3;

  localparam logic [1:0] CLR_NONE = 2'h0;
  localparam logic [1:0] CLR_FALL = 2'h1;
  localparam logic [1:0] CLR_RISE = 2'h2;
  localparam logic [1:0] CLR_BOTH = 2'h3;

  typedef struct packed {
    logic overflow_at_high_flag;
    logic overflow_at_low_flag;
    logic overflow_irq_enable;
    logic capture_irq_edge_select;
    logic [1:0] counter_clear_select;
    logic [1:0] count_clock_select;
  } timer_mode_reg_t;

  typedef struct packed {
    logic timer_irq_request_flag;
    logic timer_irq_enable;
    logic filter_select;
    logic capture_pin_function_select;
  } ctl_reg_t;

  localparam timer_mode_reg_t MODE_RST = 8'h00;
  localparam ctl_reg_t CTL_RST = 4'h0;

  typedef enum logic [1:0] {PWR_ACTIVE, PWR_WATCH, PWR_SUB} pwr_mode_t;

  typedef struct packed {
    logic rise;
    logic fall;
  } edge_t;

endpackage

// File: src/glitch_filter.sv
// Five-stage majority-free match filter for the capture input.
// Assumes din_i is already synchronised to clk_i and sample_i is a one-cycle enable.
`timescale 1ns/1ps
module glitch_filter #(
  parameter int DEPTH = tmr_pkg::FILT_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sample_i,
  input wire logic din_i,
  output logic dout_o
);
  import tmr_pkg::*;

  logic [DEPTH-1:0] chain_ff;
  logic out_ff;

  wire all_hi = &chain_ff;
  wire all_lo = ~|chain_ff;

  // The chain starts all high so the output only settles after five low samples.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      chain_ff <= '1;
      out_ff <= 1'b0;
    end
    else
    begin
      if (sample_i)
        chain_ff <= {chain_ff[DEPTH-2:0], din_i};
      if (all_hi)
        out_ff <= 1'b1;
      else if (all_lo)
        out_ff <= 1'b0;
    end
  end

  assign dout_o = out_ff;

  property p_filter_agree;
    @(posedge clk_i) disable iff (rst_i)
      (out_ff != $past(out_ff)) |-> ($past(all_hi) || $past(all_lo));
  endproperty
  a_filter_agree: assert property (p_filter_agree)
    else $error("Filter output changed while the latches disagreed.");

endmodule

// File: src/count_clock_gen.sv
// Count clock source: system clock dividers and a synchronised watch clock divided by 4.
// Assumes watch_clk_i is a free-running level from an unrelated oscillator.
`timescale 1ns/1ps
module count_clock_gen (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic watch_clk_i,
  input wire logic [1:0] cks_i,
  output logic count_tick_o,
  output logic sample_tick_o
);
  import tmr_pkg::*;

  logic [DIV_W-1:0] div_ff;
  logic wsync1_ff;
  logic wsync2_ff;
  logic wprev_ff;
  logic [WDIV_W-1:0] wdiv_ff;
  logic sel_prev_ff;

  function automatic logic pick_level(input logic [1:0] cks, input logic [DIV_W-1:0] div,
                                      input logic wlev);
    if (cks == CKS_D64)
      return div[DIV64_BIT];
    else if (cks == CKS_D32)
      return div[DIV32_BIT];
    else if (cks == CKS_D2)
      return div[DIV2_BIT];
    else
      return wlev;
  endfunction

  wire watch_rise = wsync2_ff & ~wprev_ff;
  wire sel_level = pick_level(cks_i, div_ff, wdiv_ff[WDIV_W-1]);

  // Watch clock is asynchronous, so it is resynchronised; this costs up to one
  // system clock of jitter on each count period.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      div_ff <= '0;
      wsync1_ff <= 1'b0;
      wsync2_ff <= 1'b0;
      wprev_ff <= 1'b0;
      wdiv_ff <= '0;
      sel_prev_ff <= 1'b0;
    end
    else
    begin
      div_ff <= div_ff + DIV_ONE;
      wsync1_ff <= watch_clk_i;
      wsync2_ff <= wsync1_ff;
      wprev_ff <= wsync2_ff;
      if (watch_rise)
        wdiv_ff <= wdiv_ff + WDIV_ONE;
      sel_prev_ff <= sel_level;
    end
  end

  // A select write that drops the level is seen as a falling edge and counts once.
  assign count_tick_o = sel_prev_ff & ~sel_level;
  assign sample_tick_o = ~sel_prev_ff & sel_level;

  property p_tick_spacing;
    @(posedge clk_i) disable iff (rst_i)
      count_tick_o |=> !count_tick_o;
  endproperty
  a_tick_spacing: assert property (p_tick_spacing)
    else $error("Count ticks arrived in two consecutive cycles.");

endmodule

// File: bench/pin_source.sv
// Behavioural source for the capture input pin of the timer.
// Assumes the bench calls hold() right after a rising clock edge.
`timescale 1ns/1ps
module pin_source #(
  parameter int MIN_CYC = 2
) (
  input wire logic clk_i,
  output logic pin_o
);
  initial pin_o = 1'b0;

  // Pulses shorter than two clocks are stretched, since such pulses may be lost unfiltered.
  task automatic hold(input logic lvl, input int cycles);
    int n;
    n = (cycles < MIN_CYC) ? MIN_CYC : cycles;
    pin_o <= lvl;
    repeat (n) @(posedge clk_i);
  endtask
endmodule

// File: bench/tb.sv
// Self-checking bench for the capture/interval timer over classic Wishbone.
// Assumes the assertions live in the design files and one 200 MHz clock.
`timescale 1ns/1ps
module tb;
  import tmr_pkg::*;
  typedef struct packed {
    logic [IDX_W-1:0] idx;
    logic [7:0] wd;
    logic [7:0] exp;
  } row_t;
  logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, irq, wclk, pin;
  logic [ADDR_W-1:0] wb_adr;
  logic [3:0] wb_sel;
  logic [DATA_W-1:0] wb_wd, wb_rd, q;
  pwr_mode_t pwr;
  logic sub;
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;
  row_t rows [6] = '{
    '{IDX_MODE, 8'hFF, 8'h7F}, '{IDX_MODE, 8'h15, 8'h15}, '{IDX_MODE, 8'h2A, 8'h2A},
    '{IDX_CTL, 8'h0C, 8'h04}, '{16'h0010, 8'hFF, 8'h00}, '{IDX_FALL_CAP, 8'hAA, 8'h00}};

  filtered_capture_interval_timer i_filtered_capture_interval_timer (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wd), .wb_dat_o(wb_rd),
    .wb_ack_o(wb_ack), .capture_pin_i(pin), .watch_clk_i(wclk), .pwr_mode_i(pwr),
    .subclk_is_watch_div2_i(sub), .timer_irq_o(irq));
  pin_source i_pin_source (.clk_i(clk_i), .pin_o(pin));

  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  // The watch clock period is not a multiple of the system clock, so phases drift.
  initial
  begin
    wclk = 1'b0;
    forever #31.3 wclk = ~wclk;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, cycles, 40000);
      mismatches++;
      close_out();
    end
  end

  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input logic [DATA_W-1:0] got, input int lo, input int hi);
    total_checks++;
    if (got < lo || got > hi || $isunknown(got))
    begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  task automatic wb(input logic we, input logic [IDX_W-1:0] idx, input logic [7:0] d);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= {idx, 2'b00};
    wb_wd <= {24'h00_0000, d};
    wb_sel <= 4'hF;
    @(posedge clk_i);
    while (wb_ack !== 1'b1)
      @(posedge clk_i);
    q = wb_rd;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    @(posedge clk_i);
  endtask

  initial
  begin
    rst_i = 1'b1;
    {wb_cyc, wb_stb, wb_we} = 3'h0;
    wb_adr = '0;
    wb_sel = 4'h0;
    wb_wd = RD_ZERO;
    pwr = PWR_ACTIVE;
    sub = 1'b0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    foreach (rows[k])
    begin
      wb(1'b0, rows[k].idx, 8'h00);
      chk(q, RD_ZERO);
    end
    repeat (16384 - 240) @(posedge clk_i);
    wb(1'b0, IDX_MODE, 8'h00);
    chk(q, 32'h0000_0000);
    repeat (400) @(posedge clk_i);
    wb(1'b0, IDX_MODE, 8'h00);
    chk(q, 32'h0000_0040);
    $display("test reset and default count done");
    foreach (rows[k])
    begin
      wb(1'b1, rows[k].idx, rows[k].wd);
      wb(1'b0, rows[k].idx, 8'h00);
      chk(q, {24'h00_0000, rows[k].exp});
    end
    $display("test register table done");
    wb(1'b1, IDX_MODE, 8'h0E);
    wb(1'b1, IDX_CTL, 8'h05);
    i_pin_source.hold(1'b1, 40);
    i_pin_source.hold(1'b0, 40);
    i_pin_source.hold(1'b1, 40);
    wb(1'b0, IDX_FALL_CAP, 8'h00);
    chk_rng(q, 17, 23);
    wb(1'b0, IDX_RISE_CAP, 8'h00);
    chk_rng(q, 17, 23);
    chk(irq, 1'b1);
    wb(1'b1, IDX_CTL, 8'h05);
    repeat (3) @(posedge clk_i);
    chk(irq, 1'b0);
    $display("test capture and clear done");
    i_pin_source.hold(1'b0, 10);
    wb(1'b1, IDX_CTL, 8'h04);
    i_pin_source.hold(1'b1, 10);
    wb(1'b1, IDX_CTL, 8'h05);
    repeat (6) @(posedge clk_i);
    wb(1'b0, IDX_CTL, 8'h00);
    chk(q, 32'h0000_000D);
    $display("test spurious edge done");
    wb(1'b1, IDX_MODE, 8'h22);
    wb(1'b1, IDX_CTL, 8'h05);
    repeat (600) @(posedge clk_i);
    wb(1'b0, IDX_MODE, 8'h00);
    chk(q, 32'h0000_00A2);
    chk(irq, 1'b1);
    wb(1'b1, IDX_MODE, 8'h22);
    wb(1'b0, IDX_MODE, 8'h00);
    chk(q, 32'h0000_0022);
    i_pin_source.hold(1'b0, 10);
    wb(1'b1, IDX_CTL, 8'h04);
    repeat (600) @(posedge clk_i);
    wb(1'b0, IDX_MODE, 8'h00);
    chk(q, 32'h0000_0062);
    $display("test overflow done");
    wb(1'b1, IDX_MODE, 8'h02);
    wb(1'b1, IDX_CTL, 8'h06);
    wb(1'b1, IDX_CTL, 8'h07);
    repeat (20) @(posedge clk_i);
    wb(1'b1, IDX_CTL, 8'h07);
    i_pin_source.hold(1'b1, 4);
    i_pin_source.hold(1'b0, 30);
    wb(1'b0, IDX_CTL, 8'h00);
    chk(q, 32'h0000_0007);
    i_pin_source.hold(1'b1, 30);
    repeat (20) @(posedge clk_i);
    wb(1'b0, IDX_CTL, 8'h00);
    chk(q, 32'h0000_000F);
    $display("test filter done");
    // Both edges clear the counter, so the halt starts from a small known count.
    wb(1'b1, IDX_MODE, 8'h0E);
    i_pin_source.hold(1'b0, 30);
    i_pin_source.hold(1'b1, 30);
    pwr <= PWR_WATCH;
    repeat (300) @(posedge clk_i);
    pwr <= PWR_SUB;
    sub <= 1'b1;
    repeat (300) @(posedge clk_i);
    wb(1'b0, IDX_MODE, 8'h00);
    chk(q, 32'h0000_000E);
    pwr <= PWR_ACTIVE;
    repeat (600) @(posedge clk_i);
    wb(1'b0, IDX_MODE, 8'h00);
    chk(q, 32'h0000_008E);
    $display("test power halt done");
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, IDX_MODE, 8'h00);
    chk(q, RD_ZERO);
    wb(1'b0, IDX_RISE_CAP, 8'h00);
    chk(q, RD_ZERO);
    wb(1'b0, IDX_FALL_CAP, 8'h00);
    chk(q, RD_ZERO);
    $display("test mid-run reset done");
    close_out();
  end
endmodule
